/* File: hdl/itic_defines.vh */
// constants for the integration test input capture block
`ifndef ITIC_DEFINES_VH
`define ITIC_DEFINES_VH

`define ITIC_ADDR_W 12
`define ITIC_OFF_CONTROL 12'hF00
`define ITIC_OFF_CAPTURE_ONE 12'hF20
`define ITIC_OFF_CAPTURE_TWO 12'hF24

`define ITIC_ONE_W 10
`define ITIC_TWO_W 12
`define ITIC_TEST_MODE_BIT 0
`define ITIC_CONTROL_RESET 1'b0
`define ITIC_CAPTURE_ONE_RESET 10'h000
`define ITIC_CAPTURE_TWO_RESET 12'h000

`define ITIC_ONE_CALIB_ACK 9
`define ITIC_ONE_CS1_LANE_POL 8
`define ITIC_ONE_CS_POL_LO 4
`define ITIC_ONE_CS1_WIDTH_LO 2
`define ITIC_ONE_BIG_ENDIAN 1
`define ITIC_ONE_SELF_REFRESH 0
`define ITIC_TWO_BOOT_DELAY 11
`define ITIC_TWO_STROBE_LO 7
`define ITIC_TWO_CLOCK_EN_LO 3
`define ITIC_TWO_DATA_MASK 2
`define ITIC_TWO_BACKOFF 1
`define ITIC_TWO_GRANT 0

`define ITIC_SEL_CONTROL 2'h0
`define ITIC_SEL_ONE 2'h1
`define ITIC_SEL_TWO 2'h2
`define ITIC_SEL_NONE 2'h3

`define ITIC_RESP_OKAY 2'h0
`define ITIC_RESP_SLVERR 2'h2

`define ITIC_WAIT_STATES 1

`endif

/* File: hdl/itic_sync.v */
// two-flop synchroniser for the live side-band inputs
`timescale 1ns/1ps
module itic_sync #(
    parameter W = 1
) (
    input wire clk,
    input wire ce,
    input wire reset,
    input wire [W-1:0] async_in,
    output reg [W-1:0] sync_out
);
    reg [W-1:0] meta;

    always @(posedge clk)
    begin
        if (reset)
        begin
            meta <= {W{1'b0}};
            sync_out <= {W{1'b0}};
        end
        else if (ce)
        begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule // itic_sync

/* File: hdl/itic_capture_reg.v */
// one capture register: stored field, read select and core-side select
`timescale 1ns/1ps
module itic_capture_reg #(
    parameter W = 10,
    parameter [W-1:0] RESET_VALUE = {W{1'b0}}
) (
    input wire clk,
    input wire ce,
    input wire bus_reset,
    input wire por_reset,
    input wire test_mode,
    input wire wr_en,
    input wire [W-1:0] wr_data,
    input wire [W-1:0] live,
    output reg [W-1:0] stored,
    output wire [W-1:0] read_value,
    output reg [W-1:0] core_value
);
    // stored fields only clear on power-on reset
    always @(posedge clk)
    begin
        if (por_reset)
            stored <= RESET_VALUE;
        else if (ce && wr_en && test_mode)
            stored <= wr_data;
    end

    assign read_value = test_mode ? stored : live;

    // the controller core sees the same selection
    always @(posedge clk)
    begin
        if (bus_reset || por_reset)
            core_value <= {W{1'b0}};
        else if (ce)
            core_value <= test_mode ? stored : live;
    end
endmodule // itic_capture_reg

/* File: hdl/itic_top.v */
// integration test input capture registers behind an axi4-lite slave
`timescale 1ns/1ps
`include "itic_defines.vh"
module itic_top #(
    parameter ADDR_W = `ITIC_ADDR_W
) (
    input wire clk,
    input wire ce,
    input wire reset,
    input wire por_reset,
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire delay_line_calib_ack_in,
    input wire cs1_byte_lane_polarity,
    input wire cs3_polarity,
    input wire cs2_polarity,
    input wire cs1_polarity,
    input wire cs0_polarity,
    input wire [1:0] cs1_memory_width,
    input wire big_endian_select,
    input wire self_refresh_request,
    input wire boot_delay,
    input wire [3:0] byte_strobe_enable,
    input wire [3:0] initial_clock_enable,
    input wire initial_data_mask,
    input wire ext_bus_backoff,
    input wire ext_bus_grant,
    output reg integration_test_control,
    output wire [`ITIC_ONE_W-1:0] core_capture_one,
    output wire [`ITIC_TWO_W-1:0] core_capture_two
);
    localparam ONE_W = `ITIC_ONE_W;
    localparam TWO_W = `ITIC_TWO_W;
    // register byte addresses at the bus address width
    localparam [ADDR_W-1:0] OFF_CONTROL = `ITIC_OFF_CONTROL;
    localparam [ADDR_W-1:0] OFF_ONE = `ITIC_OFF_CAPTURE_ONE;
    localparam [ADDR_W-1:0] OFF_TWO = `ITIC_OFF_CAPTURE_TWO;

    wire bus_rst;
    wire [ONE_W-1:0] live_one_raw;
    wire [TWO_W-1:0] live_two_raw;
    wire [ONE_W-1:0] live_one;
    wire [TWO_W-1:0] live_two;
    wire [ONE_W-1:0] stored_one;
    wire [TWO_W-1:0] stored_two;
    wire [ONE_W-1:0] read_one;
    wire [TWO_W-1:0] read_two;

    reg aw_held;
    reg w_held;
    reg wr_wait;
    reg [ADDR_W-1:0] wr_addr;
    reg [31:0] wr_data;
    reg [3:0] wr_strb;
    reg rd_wait;
    reg [ADDR_W-1:0] rd_addr;

    wire aw_take;
    wire w_take;
    wire aw_now;
    wire w_now;
    wire wr_do;
    wire [1:0] wr_sel;
    wire [1:0] rd_sel;
    wire [31:0] merged_ctrl;
    wire [31:0] merged_one;
    wire [31:0] merged_two;
    reg [31:0] next_rdata;

    assign bus_rst = reset | por_reset;

    // register map decode, shared by both channels
    function [1:0] reg_select;
        input [ADDR_W-1:0] addr;
        begin
            if (addr[ADDR_W-1:2] == OFF_CONTROL[ADDR_W-1:2])
                reg_select = `ITIC_SEL_CONTROL;
            else if (addr[ADDR_W-1:2] == OFF_ONE[ADDR_W-1:2])
                reg_select = `ITIC_SEL_ONE;
            else if (addr[ADDR_W-1:2] == OFF_TWO[ADDR_W-1:2])
                reg_select = `ITIC_SEL_TWO;
            else
                reg_select = `ITIC_SEL_NONE;
        end
    endfunction

    // byte-lane merge of write data over the current value
    function [31:0] merge_bytes;
        input [31:0] old_value;
        input [31:0] new_value;
        input [3:0] strb;
        integer i;
        begin
            merge_bytes = old_value;
            for (i = 0; i < 4; i = i + 1)
            begin
                if (strb[i])
                    merge_bytes[i*8 +: 8] = new_value[i*8 +: 8];
            end
        end
    endfunction

    // bus response for a decoded register select
    function [1:0] access_resp;
        input [1:0] sel;
        begin
            if (sel == `ITIC_SEL_NONE)
                access_resp = `ITIC_RESP_SLVERR;
            else
                access_resp = `ITIC_RESP_OKAY;
        end
    endfunction

    // pin placement in capture register one
    assign live_one_raw[`ITIC_ONE_CALIB_ACK] = delay_line_calib_ack_in;
    assign live_one_raw[`ITIC_ONE_CS1_LANE_POL] = cs1_byte_lane_polarity;
    assign live_one_raw[`ITIC_ONE_CS_POL_LO + 3] = cs3_polarity;
    assign live_one_raw[`ITIC_ONE_CS_POL_LO + 2] = cs2_polarity;
    assign live_one_raw[`ITIC_ONE_CS_POL_LO + 1] = cs1_polarity;
    assign live_one_raw[`ITIC_ONE_CS_POL_LO] = cs0_polarity;
    assign live_one_raw[`ITIC_ONE_CS1_WIDTH_LO +: 2] = cs1_memory_width;
    assign live_one_raw[`ITIC_ONE_BIG_ENDIAN] = big_endian_select;
    assign live_one_raw[`ITIC_ONE_SELF_REFRESH] = self_refresh_request;

    // pin placement in capture register two
    assign live_two_raw[`ITIC_TWO_BOOT_DELAY] = boot_delay;
    assign live_two_raw[`ITIC_TWO_STROBE_LO +: 4] = byte_strobe_enable;
    assign live_two_raw[`ITIC_TWO_CLOCK_EN_LO +: 4] = initial_clock_enable;
    assign live_two_raw[`ITIC_TWO_DATA_MASK] = initial_data_mask;
    assign live_two_raw[`ITIC_TWO_BACKOFF] = ext_bus_backoff;
    assign live_two_raw[`ITIC_TWO_GRANT] = ext_bus_grant;

    itic_sync #(
        .W(ONE_W + TWO_W)
    ) u_sync (
        .clk(clk),
        .ce(ce),
        .reset(bus_rst),
        .async_in({live_two_raw, live_one_raw}),
        .sync_out({live_two, live_one})
    );

    // write channel
    assign s_axi_awready = ~aw_held;
    assign s_axi_wready = ~w_held;
    assign aw_take = s_axi_awvalid & ~aw_held;
    assign w_take = s_axi_wvalid & ~w_held;
    assign aw_now = aw_held | aw_take;
    assign w_now = w_held | w_take;
    assign wr_do = wr_wait & ce;
    assign wr_sel = reg_select(wr_addr);

    assign merged_ctrl = merge_bytes({{31{1'b0}}, integration_test_control}, wr_data, wr_strb);
    assign merged_one = merge_bytes({{(32-ONE_W){1'b0}}, stored_one}, wr_data, wr_strb);
    assign merged_two = merge_bytes({{(32-TWO_W){1'b0}}, stored_two}, wr_data, wr_strb);

    always @(posedge clk)
    begin
        if (bus_rst)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            wr_wait <= 1'b0;
            wr_addr <= {ADDR_W{1'b0}};
            wr_data <= 32'h0000_0000;
            wr_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `ITIC_RESP_OKAY;
        end
        else if (ce)
        begin
            if (aw_take)
            begin
                aw_held <= 1'b1;
                wr_addr <= s_axi_awaddr;
            end
            if (w_take)
            begin
                w_held <= 1'b1;
                wr_data <= s_axi_wdata;
                wr_strb <= s_axi_wstrb;
            end
            // one cycle of wait once both halves are in
            if (aw_now && w_now && !wr_wait && !s_axi_bvalid)
                wr_wait <= 1'b1;
            // response raised once the wait cycle is over
            if (wr_wait)
            begin
                wr_wait <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= access_resp(wr_sel);
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                aw_held <= 1'b0;
                w_held <= 1'b0;
            end
        end
    end

    // control register, cleared by either reset
    always @(posedge clk)
    begin
        if (bus_rst)
            integration_test_control <= `ITIC_CONTROL_RESET;
        else if (wr_do && wr_sel == `ITIC_SEL_CONTROL)
            integration_test_control <= merged_ctrl[`ITIC_TEST_MODE_BIT];
    end

    itic_capture_reg #(
        .W(ONE_W),
        .RESET_VALUE(`ITIC_CAPTURE_ONE_RESET)
    ) u_capture_one (
        .clk(clk),
        .ce(ce),
        .bus_reset(reset),
        .por_reset(por_reset),
        .test_mode(integration_test_control),
        .wr_en(wr_do && wr_sel == `ITIC_SEL_ONE),
        .wr_data(merged_one[ONE_W-1:0]),
        .live(live_one),
        .stored(stored_one),
        .read_value(read_one),
        .core_value(core_capture_one)
    );

    itic_capture_reg #(
        .W(TWO_W),
        .RESET_VALUE(`ITIC_CAPTURE_TWO_RESET)
    ) u_capture_two (
        .clk(clk),
        .ce(ce),
        .bus_reset(reset),
        .por_reset(por_reset),
        .test_mode(integration_test_control),
        .wr_en(wr_do && wr_sel == `ITIC_SEL_TWO),
        .wr_data(merged_two[TWO_W-1:0]),
        .live(live_two),
        .stored(stored_two),
        .read_value(read_two),
        .core_value(core_capture_two)
    );

    // read channel
    // address refused from acceptance until the read handshake
    assign s_axi_arready = ~rd_wait & ~s_axi_rvalid;
    assign rd_sel = reg_select(rd_addr);

    always @*
    begin
        case (rd_sel)
            `ITIC_SEL_CONTROL: next_rdata = {{31{1'b0}}, integration_test_control};
            `ITIC_SEL_ONE: next_rdata = {{(32-ONE_W){1'b0}}, read_one};
            `ITIC_SEL_TWO: next_rdata = {{(32-TWO_W){1'b0}}, read_two};
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    always @(posedge clk)
    begin
        if (bus_rst)
        begin
            rd_wait <= 1'b0;
            rd_addr <= {ADDR_W{1'b0}};
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `ITIC_RESP_OKAY;
        end
        else if (ce)
        begin
            if (s_axi_arvalid && s_axi_arready)
            begin
                rd_wait <= 1'b1;
                rd_addr <= s_axi_araddr;
            end
            if (rd_wait)
            begin
                rd_wait <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= next_rdata;
                s_axi_rresp <= access_resp(rd_sel);
            end
            if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end
endmodule // itic_top

/* File: dv/itic_checker_asserts.sv */
// assertions on bus timing and core-side capture outputs
`timescale 1ns/1ps
module itic_checker (
    input wire clk,
    input wire reset,
    input wire por_reset,
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire integration_test_control,
    input wire [9:0] core_capture_one,
    input wire [11:0] core_capture_two
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset || por_reset);
    wire aw_w = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    a_write_wait: assert property (aw_w |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write answer not after one wait cycle");
    a_read_wait: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_rvalid ##1 s_axi_rvalid)
        else $error("read answer not after one wait cycle");
    a_bvalid_drops: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer not ended by handshake");
    a_rvalid_drops: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer not ended by handshake");
    a_busy_refuses: assert property ((!s_axi_bvalid || !s_axi_awready && !s_axi_wready)
        && (!s_axi_rvalid || !s_axi_arready)) else $error("request taken while answer pending");
    a_control_reset: assert property ($fell(reset) || $fell(por_reset) |-> !integration_test_control)
        else $error("test mode set after reset");
    a_control_write: assert property (aw_w && s_axi_awaddr[11:2] == 10'h3c0 && s_axi_wstrb[0]
        |=> ##1 integration_test_control == $past(s_axi_wdata[0], 2)) else $error("test mode not written");
    a_test_core_held: assert property (integration_test_control && $stable(integration_test_control)
        && !s_axi_bvalid && !$past(s_axi_bvalid) |-> $stable(core_capture_one) && $stable(core_capture_two))
        else $error("core capture moved in test mode without write");
endmodule // itic_checker

/* File: dv/tb.sv */
// self-checking bench for the capture registers
`timescale 1ns/1ps
`include "itic_defines.vh"
module tb;
    logic clk, reset, por_reset, ce;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, r, st1, st2;
    logic [3:0] s_axi_wstrb, s;
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, integration_test_control;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [9:0] core_capture_one;
    wire [11:0] core_capture_two;
    logic [21:0] pins;
    integer fail_count, num_checks, cycles, i;
    itic_top dut_u (.clk, .ce, .reset, .por_reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .integration_test_control, .core_capture_one, .core_capture_two,
        .delay_line_calib_ack_in(pins[9]), .cs1_byte_lane_polarity(pins[8]), .cs3_polarity(pins[7]),
        .cs2_polarity(pins[6]), .cs1_polarity(pins[5]), .cs0_polarity(pins[4]),
        .cs1_memory_width(pins[3:2]), .big_endian_select(pins[1]), .self_refresh_request(pins[0]),
        .boot_delay(pins[21]), .byte_strobe_enable(pins[20:17]), .initial_clock_enable(pins[16:13]),
        .initial_data_mask(pins[12]), .ext_bus_backoff(pins[11]), .ext_bus_grant(pins[10]));
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task complete_run;
    begin
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    end
    endtask
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            fail_count = fail_count + 1;
            complete_run;
        end
    end
    task chk(input string n, input [31:0] seen, input [31:0] exp);
    begin
        num_checks = num_checks + 1;
        if (seen !== exp)
        begin
            fail_count = fail_count + 1;
            $display("Error %s expected %h seen %h", n, exp, seen);
        end
    end
    endtask
    // byte lanes of n replace those of o
    function [31:0] merge(input [31:0] o, input [31:0] n, input [3:0] m);
        integer k;
        begin
            merge = o;
            for (k = 0; k < 4; k = k + 1)
                if (m[k])
                    merge[8*k+:8] = n[8*k+:8];
        end
    endfunction
    task wr(input [11:0] a, input [31:0] d, input [3:0] m, input [1:0] er);
    begin
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= m;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready === 1'b1)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready === 1'b1)
                s_axi_wvalid <= 1'b0;
        end
        while (s_axi_awvalid || s_axi_wvalid);
        while (s_axi_bvalid !== 1'b1)
            @(posedge clk);
        s_axi_bready <= 1'b0;
        chk("bresp", s_axi_bresp, er);
    end
    endtask
    task rd(input [11:0] a, input [31:0] e, input [1:0] er);
    begin
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        @(posedge clk);
        while (s_axi_arready !== 1'b1)
            @(posedge clk);
        s_axi_arvalid <= 1'b0;
        @(posedge clk);
        while (s_axi_rvalid !== 1'b1)
            @(posedge clk);
        s_axi_rready <= 1'b0;
        chk("rresp", s_axi_rresp, er);
        chk("rdata", s_axi_rdata, e);
    end
    endtask
    initial
    begin
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 0;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready, pins} = 0;
        reset = 1'b1;
        por_reset = 1'b1;
        ce = 1'b1;
        fail_count = 0;
        num_checks = 0;
        cycles = 0;
        void'($urandom(6));
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        por_reset <= 1'b0;
        rd(`ITIC_OFF_CONTROL, 0, `ITIC_RESP_OKAY);
        for (i = 0; i < 6; i = i + 1)
        begin
            r = (i == 0) ? 32'hffff_ffff : $urandom;
            pins <= r[21:0];
            wr(`ITIC_OFF_CAPTURE_ONE, r, 4'hf, `ITIC_RESP_OKAY);
            wr(`ITIC_OFF_CAPTURE_TWO, ~r & 32'h0000_0fff, 4'hf, `ITIC_RESP_OKAY);
            rd(`ITIC_OFF_CAPTURE_ONE, {22'h0, r[9:0]}, `ITIC_RESP_OKAY);
            rd(`ITIC_OFF_CAPTURE_TWO, {20'h0, r[21:10]}, `ITIC_RESP_OKAY);
        end
        chk("core_one_live", {22'h0, core_capture_one}, {22'h0, r[9:0]});
        ce <= 1'b0;
        pins <= ~r[21:0];
        repeat (4) @(posedge clk);
        chk("core_one_frozen", {22'h0, core_capture_one}, {22'h0, r[9:0]});
        ce <= 1'b1;
        rd(`ITIC_OFF_CAPTURE_TWO, {20'h0, ~r[21:10]}, `ITIC_RESP_OKAY);
        wr(`ITIC_OFF_CONTROL, 1, 4'h1, `ITIC_RESP_OKAY);
        chk("test_mode", {31'h0, integration_test_control}, 1);
        rd(`ITIC_OFF_CAPTURE_ONE, 0, `ITIC_RESP_OKAY);
        rd(`ITIC_OFF_CAPTURE_TWO, 0, `ITIC_RESP_OKAY);
        st1 = 0;
        st2 = 0;
        for (i = 0; i < 8; i = i + 1)
        begin
            r = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h0 : $urandom;
            s = (i < 2) ? 4'hf : i[3:0];
            pins <= ~r[21:0];
            wr(`ITIC_OFF_CAPTURE_ONE, r, s, `ITIC_RESP_OKAY);
            wr(`ITIC_OFF_CAPTURE_TWO, r & 32'h0000_0fff, s, `ITIC_RESP_OKAY);
            st1 = merge(st1, r, s) & 32'h0000_03ff;
            st2 = merge(st2, r, s) & 32'h0000_0fff;
            rd(`ITIC_OFF_CAPTURE_ONE, st1, `ITIC_RESP_OKAY);
            rd(`ITIC_OFF_CAPTURE_TWO, st2, `ITIC_RESP_OKAY);
            chk("core_one", {22'h0, core_capture_one}, st1);
            chk("core_two", {20'h0, core_capture_two}, st2);
        end
        wr(12'hf40, r, 4'hf, `ITIC_RESP_SLVERR);
        rd(12'hf40, 0, `ITIC_RESP_SLVERR);
        @(posedge clk) reset <= 1'b1;
        @(posedge clk) reset <= 1'b0;
        rd(`ITIC_OFF_CONTROL, 0, `ITIC_RESP_OKAY);
        wr(`ITIC_OFF_CONTROL, 1, 4'h1, `ITIC_RESP_OKAY);
        rd(`ITIC_OFF_CAPTURE_ONE, st1, `ITIC_RESP_OKAY);
        @(posedge clk) por_reset <= 1'b1;
        @(posedge clk) por_reset <= 1'b0;
        wr(`ITIC_OFF_CONTROL, 1, 4'h1, `ITIC_RESP_OKAY);
        rd(`ITIC_OFF_CAPTURE_TWO, 0, `ITIC_RESP_OKAY);
        complete_run;
    end
endmodule // tb
bind itic_top itic_checker chk_u (.clk, .reset, .por_reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .integration_test_control, .core_capture_one, .core_capture_two);
